// >>> rtl/sadc_top.v
`timescale 1ns/10ps
`include "sadc_map.vh"
// Overview of operation
// - While waiting, serial_in is shifted in on each converter clock rise.
// - First sampled one is the start bit; leading zeros are ignored.
// - A 2 to 4 bit multiplexer word follows the start bit.
// - After the last address bit, half-period settle; status rises then.
// - serial_in is ignored from conversion start until deselect.
// - Serial output leaves high impedance, drives a leading zero.
// - Each comparator decision appears on serial output at a falling edge.
// - Result leaves most significant bit first, readable at once.
// - Conversion ends after 8 periods; status drops half a cycle later.
// - All 8 result bits are held in an output shift register.
// - Without shift enable, LSB-first copy follows the MSB stream.
// - After the LSB-first stream, serial output stays low until deselect.
// - With shift enable, LSB held while high, shifted out when low.
// - Single-channel variant sends only the MSB-first stream.
// - Every internal register except the result FIFO and sclk_d_ff is cleared while chip select is high.
// - serial_in is sampled only while serial output is high impedance.
// - Trial code spans 256 steps of reference divided by 256.
// - Comparator is strobed at the end of each conversion period.
// - Address word: single/pair bit, sign bit, then select bits.
// - Single-channel variant takes no address bits after the start bit.
module sadc_top (
    input  wire       mclk,
    input  wire       srst,
    input  wire       ce,
    input  wire       cs_n,
    input  wire       sclk,
    input  wire       serial_in,
    input  wire       lsb_first_shift_en_n,
    input  wire       se_present,
    input  wire [1:0] chan_cfg,
    input  wire       comp_gt,
    output reg        serial_out,
    output reg        serial_out_oe_n,
    output reg        conversion_status,
    output reg        conv_done,
    output wire [7:0] dac_code,
    output reg        single_or_pair_bit,
    output reg  [2:0] mux_pos_chan,
    output reg  [2:0] mux_neg_chan,
    output reg        mux_neg_common,
    output wire [7:0] result_data,
    output wire       result_valid,
    input  wire       result_ready
);
    localparam [5:0] ST_IDLE   = 6'h01;
    localparam [5:0] ST_ADDR   = 6'h02;
    localparam [5:0] ST_SETTLE = 6'h04;
    localparam [5:0] ST_CONV   = 6'h08;
    localparam [5:0] ST_LSBF   = 6'h10;
    localparam [5:0] ST_TAIL   = 6'h20;

    reg  [5:0] state_ff;
    reg  [5:0] nxt_state;
    reg        sclk_d_ff;
    reg  [3:0] addr_ff;
    reg  [3:0] nxt_addr;
    reg  [3:0] cnt_ff;
    reg  [3:0] nxt_cnt;
    reg  [7:0] shreg_ff;
    reg  [7:0] nxt_shreg;
    reg        nxt_dout;
    reg        nxt_oe_n;
    reg        nxt_status;
    reg        nxt_done;
    reg        push_ff;
    reg        nxt_push;
    reg        sar_load;
    reg        sar_step;
    reg  [3:0] alen;
    reg        dec_sgl;
    reg        dec_sign;
    reg  [1:0] dec_sel;
    wire       clr;
    wire       rise;
    wire       fall;
    wire       fifo_in_ready;

    // Deselect, not only reset, clears all but the result FIFO and sclk_d_ff
    // clear on deselect
    assign clr  = srst | cs_n;
    assign rise = sclk & ~sclk_d_ff;
    assign fall = ~sclk & sclk_d_ff;

    always @* begin
        case (chan_cfg)
            `SADC_CFG_2CH: alen = `SADC_ALEN_2CH;
            `SADC_CFG_4CH: alen = `SADC_ALEN_4CH;
            `SADC_CFG_8CH: alen = `SADC_ALEN_8CH;
            default:       alen = `SADC_ALEN_1CH;
        endcase
    end

    always @* begin
        dec_sgl  = 1'b0;
        dec_sign = 1'b0;
        dec_sel  = 2'b00;
        case (chan_cfg)
            `SADC_CFG_2CH: begin
                dec_sgl  = addr_ff[1];
                dec_sign = addr_ff[0];
            end
            `SADC_CFG_4CH: begin
                dec_sgl  = addr_ff[2];
                dec_sign = addr_ff[1];
                dec_sel  = {1'b0, addr_ff[0]};
            end
            `SADC_CFG_8CH: begin
                dec_sgl  = addr_ff[3];
                dec_sign = addr_ff[2];
                dec_sel  = addr_ff[1:0];
            end
            default: begin
                dec_sgl  = 1'b0;
                dec_sign = 1'b0;
                dec_sel  = 2'b00;
            end
        endcase
    end

    always @* begin
        nxt_state  = state_ff;
        nxt_addr   = addr_ff;
        nxt_cnt    = cnt_ff;
        nxt_shreg  = shreg_ff;
        nxt_dout   = serial_out;
        nxt_oe_n   = serial_out_oe_n;
        nxt_status = conversion_status;
        nxt_done   = 1'b0;
        nxt_push   = 1'b0;
        sar_load   = 1'b0;
        sar_step   = 1'b0;
        case (state_ff)
            ST_IDLE: begin
                // Full result FIFO holds off the next command
                // start bit detect
                if (rise && serial_in == `SADC_START_LEVEL &&
                    fifo_in_ready) begin
                    nxt_cnt = `SADC_CNT_RST;
                    if (alen == `SADC_ALEN_1CH) begin
                        nxt_state  = ST_SETTLE;
                        nxt_status = 1'b1;
                        nxt_oe_n   = 1'b0;
                        nxt_dout   = `SADC_LEAD_LEVEL;
                        sar_load   = 1'b1;
                    end else begin
                        nxt_state = ST_ADDR;
                    end
                end
            end
            ST_ADDR: begin
                if (rise) begin
                    nxt_addr = {addr_ff[2:0], serial_in};
                    nxt_cnt  = cnt_ff + 4'h1;
                    if (nxt_cnt == alen) begin
                        nxt_state  = ST_SETTLE;
                        nxt_status = 1'b1;
                        nxt_oe_n   = 1'b0;
                        nxt_dout   = `SADC_LEAD_LEVEL;
                        sar_load   = 1'b1;
                        nxt_cnt    = `SADC_CNT_RST;
                    end
                end
            end
            ST_SETTLE: begin
                if (fall) begin
                    nxt_state = ST_CONV;
                end
            end
            ST_CONV: begin
                if (fall) begin
                    sar_step  = 1'b1;
                    nxt_dout  = comp_gt;
                    nxt_shreg = {shreg_ff[6:0], comp_gt};
                    nxt_cnt   = cnt_ff + 4'h1;
                    if (cnt_ff == `SADC_LAST_BIT) begin
                        nxt_cnt  = `SADC_CNT_RST;
                        nxt_push = 1'b1;
                        if (chan_cfg == `SADC_CFG_1CH) begin
                            nxt_state = ST_TAIL;
                        end else begin
                            nxt_state = ST_LSBF;
                        end
                    end
                end
            end
            ST_LSBF: begin
                if (fall && (!se_present || !lsb_first_shift_en_n)) begin
                    if (cnt_ff == `SADC_LAST_BIT) begin
                        nxt_dout  = `SADC_TAIL_LEVEL;
                        nxt_state = ST_TAIL;
                    end else begin
                        nxt_dout  = shreg_ff[1];
                        nxt_shreg = {1'b0, shreg_ff[7:1]};
                        nxt_cnt   = cnt_ff + 4'h1;
                    end
                end
            end
            ST_TAIL: begin
                if (fall) begin
                    nxt_dout = `SADC_TAIL_LEVEL;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
        if ((state_ff == ST_LSBF || state_ff == ST_TAIL) &&
            conversion_status && rise) begin
            nxt_status = 1'b0;
            nxt_done   = 1'b1;
        end
    end

    always @(posedge mclk) begin
        if (clr) begin
            state_ff           <= ST_IDLE;
            addr_ff            <= `SADC_ADDR_RST;
            cnt_ff             <= `SADC_CNT_RST;
            shreg_ff           <= `SADC_CODE_RST;
            serial_out         <= `SADC_TAIL_LEVEL;
            serial_out_oe_n    <= 1'b1;
            conversion_status  <= 1'b0;
            conv_done          <= 1'b0;
            push_ff            <= 1'b0;
            single_or_pair_bit <= 1'b0;
            mux_pos_chan       <= `SADC_CHAN_RST;
            mux_neg_chan       <= `SADC_CHAN_RST;
            mux_neg_common     <= 1'b0;
        end else if (ce) begin
            state_ff          <= nxt_state;
            addr_ff           <= nxt_addr;
            cnt_ff            <= nxt_cnt;
            shreg_ff          <= nxt_shreg;
            serial_out        <= nxt_dout;
            serial_out_oe_n   <= nxt_oe_n;
            conversion_status <= nxt_status;
            conv_done         <= nxt_done;
            push_ff           <= nxt_push;
            if (state_ff == ST_SETTLE) begin
                single_or_pair_bit <= dec_sgl;
                mux_pos_chan       <= {dec_sel, dec_sign};
                mux_neg_chan       <= {dec_sel, ~dec_sign};
                mux_neg_common     <= dec_sgl;
            end
        end
    end

    always @(posedge mclk) begin
        if (srst) begin
            sclk_d_ff <= 1'b0;
        end else if (ce) begin
            sclk_d_ff <= sclk;
        end
    end

    sadc_sar u_sar (
        .mclk       (mclk),
        .clr        (clr),
        .ce         (ce),
        .load       (sar_load),
        .step       (sar_step),
        .comp_gt    (comp_gt),
        .trial_code (dac_code)
    );

    sadc_fifo #(
        .WIDTH (`SADC_RES_W),
        .DEPTH (`SADC_FIFO_DEPTH),
        .AW    (`SADC_FIFO_AW)
    ) u_fifo (
        .mclk      (mclk),
        .srst      (srst),
        .ce        (ce),
        .in_valid  (push_ff),
        .in_data   (shreg_ff),
        .in_ready  (fifo_in_ready),
        .out_valid (result_valid),
        .out_data  (result_data),
        .out_ready (result_ready)
    );
endmodule

// >>> rtl/sadc_map.vh
`ifndef SADC_MAP_VH
`define SADC_MAP_VH

// Result width and code span (256 codes)
`define SADC_RES_W        8
`define SADC_TRIAL_FIRST  8'h80
`define SADC_CODE_RST     8'h00

// Result FIFO geometry
`define SADC_FIFO_DEPTH   8
`define SADC_FIFO_AW      3

// Variant codes on chan_cfg
`define SADC_CFG_1CH      2'h0
`define SADC_CFG_2CH      2'h1
`define SADC_CFG_4CH      2'h2
`define SADC_CFG_8CH      2'h3

// Address word length after the start bit, per variant
`define SADC_ALEN_1CH     4'h0
`define SADC_ALEN_2CH     4'h2
`define SADC_ALEN_4CH     4'h3
`define SADC_ALEN_8CH     4'h4

// Last bit count in converter-clock periods; start, tail and lead levels
`define SADC_LAST_BIT     4'h7
`define SADC_START_LEVEL  1'b1
`define SADC_TAIL_LEVEL   1'b0
`define SADC_LEAD_LEVEL   1'b0

// Reset values
`define SADC_ADDR_RST     4'h0
`define SADC_CNT_RST      4'h0
`define SADC_CHAN_RST     3'h0

`endif

// >>> rtl/sadc_fifo.v
`timescale 1ns/10ps
module sadc_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             mclk,
    input  wire             srst,
    input  wire             ce,
    input  wire             in_valid,
    input  wire [WIDTH-1:0] in_data,
    output wire             in_ready,
    output reg              out_valid,
    output reg  [WIDTH-1:0] out_data,
    input  wire             out_ready
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_ff;
    reg [AW-1:0]    rd_ptr_ff;
    reg [AW:0]      count_ff;
    wire            push;
    wire            pop;

    assign in_ready = (count_ff != DEPTH[AW:0]);
    assign push     = in_valid & in_ready;
    // Refill the output register whenever it is empty or being taken
    assign pop      = (count_ff != {(AW+1){1'b0}}) &
                      (~out_valid | out_ready);

    always @(posedge mclk) begin
        if (push && ce) begin
            mem[wr_ptr_ff] <= in_data;
        end
    end

    always @(posedge mclk) begin
        if (srst) begin
            wr_ptr_ff <= {AW{1'b0}};
            rd_ptr_ff <= {AW{1'b0}};
            count_ff  <= {(AW+1){1'b0}};
            out_valid <= 1'b0;
            out_data  <= {WIDTH{1'b0}};
        end else if (ce) begin
            if (push) begin
                wr_ptr_ff <= wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= rd_ptr_ff + 1'b1;
                out_data  <= mem[rd_ptr_ff];
                out_valid <= 1'b1;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
            if (push && !pop) begin
                count_ff <= count_ff + 1'b1;
            end else if (pop && !push) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end
endmodule

// >>> rtl/sadc_sar.v
`timescale 1ns/10ps
`include "sadc_map.vh"
module sadc_sar (
    input  wire       mclk,
    input  wire       clr,
    input  wire       ce,
    input  wire       load,
    input  wire       step,
    input  wire       comp_gt,
    output reg  [7:0] trial_code
);
    reg  [7:0] res_ff;
    reg  [7:0] mask_ff;
    reg  [7:0] nxt_res;
    reg  [7:0] nxt_mask;

    always @* begin
        nxt_res  = comp_gt ? (res_ff | mask_ff) : res_ff;
        nxt_mask = {1'b0, mask_ff[7:1]};
    end

    always @(posedge mclk) begin
        if (clr) begin
            res_ff     <= `SADC_CODE_RST;
            mask_ff    <= `SADC_CODE_RST;
            trial_code <= `SADC_CODE_RST;
        end else if (ce) begin
            if (load) begin
                res_ff     <= `SADC_CODE_RST;
                mask_ff    <= `SADC_TRIAL_FIRST;
                trial_code <= `SADC_TRIAL_FIRST;
            end else if (step) begin
                res_ff     <= nxt_res;
                mask_ff    <= nxt_mask;
                trial_code <= nxt_res | nxt_mask;
            end
        end
    end
endmodule

// >>> tb/sadc_monitor.sv
`timescale 1ns/10ps
module sadc_monitor (
    input wire       mclk,
    input wire       srst,
    input wire       ce,
    input wire       cs_n,
    input wire       sclk,
    input wire       serial_out,
    input wire       serial_out_oe_n,
    input wire       conversion_status,
    input wire       conv_done,
    input wire [7:0] result_data,
    input wire       result_valid,
    input wire       result_ready
);
    reg       sclk_ff;
    reg [3:0] nfall_ff;
    wire      fall_w;
    assign fall_w = sclk_ff & ~sclk;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);
    // Falls while busy, so the span can be measured
    always @(posedge mclk) begin
        sclk_ff <= sclk;
        if (srst || !conversion_status)
            nfall_ff <= 4'h0;
        else if (ce && fall_w)
            nfall_ff <= nfall_ff + 4'h1;
    end
    sequence s_busy_on;
        $rose(conversion_status);
    endsequence
    sequence s_busy_off;
        $fell(conversion_status);
    endsequence
    hiz_idle_a: assert property (
        cs_n && ce |=> serial_out_oe_n && !conversion_status)
        else $error("output live while deselected");
    lead_zero_a: assert property (
        s_busy_on |-> !serial_out_oe_n && !serial_out)
        else $error("no leading zero");
    busy_drive_a: assert property (
        conversion_status |-> !serial_out_oe_n)
        else $error("output idle while busy");
    fall_paced_a: assert property (
        conversion_status && $past(conversion_status) && $changed(serial_out)
        |-> $past(fall_w))
        else $error("output moved off a fall");
    nine_falls_a: assert property (
        conv_done |-> nfall_ff == 4'h9)
        else $error("busy span wrong");
    done_edge_a: assert property (
        conv_done |-> s_busy_off)
        else $error("done without status drop");
    done_pulse_a: assert property (
        conv_done |=> !conv_done)
        else $error("done too long");
    word_hold_a: assert property (
        result_valid && !result_ready |=> result_valid && $stable(result_data))
        else $error("result word lost");
endmodule
bind sadc_top sadc_monitor i_mon (
    .mclk(mclk), .srst(srst), .ce(ce), .cs_n(cs_n), .sclk(sclk),
    .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n),
    .conversion_status(conversion_status), .conv_done(conv_done),
    .result_data(result_data), .result_valid(result_valid),
    .result_ready(result_ready));

// >>> tb/sadc_host.sv
`timescale 1ns/10ps
module sadc_host (
    input  wire       mclk,
    input  wire       conv_done,
    input  wire       serial_out,
    input  wire       serial_out_oe_n,
    input  wire [7:0] dac_code,
    input  wire [7:0] mux_view,
    output reg        cs_n,
    output reg        sclk,
    output reg        serial_in,
    output wire       comp_gt
);
    reg     [7:0] vin;
    reg     [7:0] mux_snap;
    integer       hp;
    integer       n_done;
    integer       n_oe_bad;
    // Decision against the 256-step trial level
    assign comp_gt = vin > dac_code;
    initial begin
        cs_n = 1'b1;
        sclk = 1'b0;
        serial_in = 1'b0;
        vin = 8'h00;
        hp = 2;
        n_done = 0;
        n_oe_bad = 0;
    end
    // Clock only moves inside a frame
    task half(input lvl);
        integer i;
        begin
            for (i = 0; i < hp; i = i + 1) begin
                @(posedge mclk);
                n_done = n_done + conv_done;
            end
            sclk <= lvl;
        end
    endtask
    task frame(input [5:0] cmd, input integer nb, output [16:0] smp);
        integer k;
        begin
            // Select low for the whole sequence
            cs_n <= 1'b0;
            // A zero, the start bit, then the address word
            for (k = nb; k >= 0; k = k - 1) begin
                half(1'b0);
                serial_in <= cmd[k];
                half(1'b1);
                n_oe_bad = n_oe_bad + !serial_out_oe_n;
            end
            for (k = 16; k >= 0; k = k - 1) begin
                half(1'b0);
                serial_in <= ~serial_in;
                half(1'b1);
                smp[k] = serial_out;
            end
            mux_snap = mux_view;
            half(1'b0);
            cs_n <= 1'b1;
            half(1'b0);
        end
    endtask
endmodule

// >>> tb/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    reg         mclk;
    reg         srst;
    reg         se_present;
    reg  [1:0]  chan_cfg;
    reg         lsb_first_shift_en_n;
    reg         result_ready;
    reg  [1:0]  rdy_mode;
    reg  [31:0] rng;
    reg  [31:0] rq;
    reg  [7:0]  expq [$];
    integer     fails;
    integer     n_compared;
    integer     k;
    integer     acc;
    reg         ok;
    reg         ce_r;
    wire        cs_n, sclk, serial_in, comp_gt, serial_out, serial_out_oe_n;
    wire        conversion_status, conv_done, single_or_pair_bit;
    wire        mux_neg_common, result_valid;
    wire [2:0]  mux_pos_chan, mux_neg_chan;
    wire [7:0]  dac_code, result_data;
    localparam [31:0] CORNERS = 32'h00FF807F;
    sadc_top i_dut (
        .mclk(mclk), .srst(srst), .ce(ce_r), .cs_n(cs_n), .sclk(sclk),
        .serial_in(serial_in), .lsb_first_shift_en_n(lsb_first_shift_en_n),
        .se_present(se_present), .chan_cfg(chan_cfg), .comp_gt(comp_gt),
        .serial_out(serial_out), .serial_out_oe_n(serial_out_oe_n),
        .conversion_status(conversion_status), .conv_done(conv_done),
        .dac_code(dac_code), .single_or_pair_bit(single_or_pair_bit),
        .mux_pos_chan(mux_pos_chan), .mux_neg_chan(mux_neg_chan),
        .mux_neg_common(mux_neg_common), .result_data(result_data),
        .result_valid(result_valid), .result_ready(result_ready));
    sadc_host i_host (
        .mclk(mclk), .conv_done(conv_done), .serial_out(serial_out),
        .serial_out_oe_n(serial_out_oe_n), .dac_code(dac_code),
        .mux_view({single_or_pair_bit, mux_pos_chan, mux_neg_chan,
                   mux_neg_common}),
        .cs_n(cs_n), .sclk(sclk), .serial_in(serial_in), .comp_gt(comp_gt));
    function [31:0] lfsr(input [31:0] x);
        lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function [7:0] sar(input [7:0] v);
        integer b;
        begin
            sar = 8'h00;
            for (b = 7; b >= 0; b = b - 1)
                if (v > (sar | (8'h01 << b)))
                    sar = sar | (8'h01 << b);
        end
    endfunction
    // First sample is the leading zero, then MSB first, then the copy
    function [16:0] exp_stream(input [7:0] c, input one, input hold);
        integer i;
        begin
            exp_stream = {1'b0, c, 8'h00};
            for (i = 1; i < 8; i = i + 1)
                exp_stream[8 - i] = !one && (hold ? c[0] : c[i]);
            exp_stream[0] = !one && hold && c[0];
        end
    endfunction
    function [7:0] exp_mux(input [1:0] cfg, input [3:0] a);
        reg [1:0] s;
        begin
            s = (cfg == 2'h3) ? a[1:0] : {1'b0, a[1] & (cfg == 2'h2)};
            exp_mux = (cfg == 2'h0) ? 8'h02 : {a[3], s, a[2], s, ~a[2], a[3]};
        end
    endfunction
    task automatic cmp(input [63:0] nm, input [16:0] e, input [16:0] g);
        begin
            n_compared = n_compared + 1;
            if (g !== e) begin
                fails = fails + 1;
                $display("CHECK FAILED %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task results;
        begin
            $display("compared %0d failed %0d", n_compared, fails);
            if (fails == 0 && n_compared > 0)
                $display("NO MISMATCHES");
            else
                $display("MISMATCHES SEEN");
            $finish;
        end
    endtask
    task run_frame(input [1:0] cfg, input [7:0] v, input hold, output ok_o);
        integer     l;
        integer     d0;
        reg  [3:0]  a;
        reg  [7:0]  mk;
        reg  [16:0] smp;
        reg  [16:0] es;
        begin
            rng = lfsr(rng);
            a = rng[3:0];
            l = (cfg == 2'h0) ? 0 : cfg + 1;
            chan_cfg <= cfg;
            se_present <= hold | rng[4];
            lsb_first_shift_en_n <= hold;
            i_host.vin <= v;
            i_host.hp = 2 + rng[6:5];
            d0 = i_host.n_done;
            expq.push_back(sar(v));
            i_host.frame((6'h01 << l) | (a >> (4 - l)), l + 1, smp);
            ok_o = (i_host.n_done == d0 + 1);
            es = exp_stream(sar(v), cfg == 2'h0, hold);
            // Minus channel is a don't-care when the common line is used
            mk = (a[3] && cfg != 2'h0) ? 8'hF1 : 8'hFF;
            if (ok_o) begin
                cmp("stream", es, smp);
                cmp("mux", exp_mux(cfg, a) & mk,
                    i_host.mux_snap & mk);
            end else
                void'(expq.pop_back());
        end
    endtask
    task drain;
        integer t;
        begin
            rdy_mode <= 2'h1;
            for (t = 0; t < 300 && expq.size() > 0; t = t + 1)
                @(posedge mclk);
            if (expq.size() > 0) begin
                fails = fails + 1;
                results;
            end
            repeat (2) @(posedge mclk);
            cmp("drained", 17'h00000, {16'h0000, result_valid});
        end
    endtask
    // Consumer stalls at random, so the buffer holds words meanwhile
    always @(posedge mclk) begin
        rq <= lfsr(rq);
        result_ready <= (rdy_mode == 2'h2) ? rq[5] : rdy_mode[0];
        if (!srst && ce_r === 1'b1 &&
            result_valid === 1'b1 && result_ready === 1'b1) begin
            if (expq.size() == 0)
                cmp("word", 17'h00000, 17'h1FFFF);
            else
                cmp("word", expq.pop_front(), result_data);
        end
    end
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    initial begin
        repeat (60000) @(posedge mclk);
        fails = fails + 1;
        results;
    end
    initial begin
        srst = 1'b1;
        ce_r = 1'b1;
        se_present = 1'b0;
        chan_cfg = 2'h0;
        lsb_first_shift_en_n = 1'b1;
        result_ready = 1'b0;
        rdy_mode = 2'h2;
        rng = 32'h2664C5E5;
        rq = 32'h2664C5E5;
        fails = 0;
        n_compared = 0;
        repeat (10) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        // Edge codes first, then random ones, over every variant
        for (k = 0; k < 16; k = k + 1) begin
            rng = lfsr(rng);
            run_frame(k[1:0], (k < 4) ? CORNERS[31 - 8 * k -: 8] : rng[15:8],
                      (k == 5) | (rng[16] & (k[1:0] != 2'h0)), ok);
            cmp("done", 17'h00001, {16'h0000, ok});
        end
        cmp("addr_oe", 17'h00000, i_host.n_oe_bad[16:0]);
        $display("test random frames done");
        drain;
        rdy_mode <= 2'h0;
        acc = 0;
        ok = 1'b1;
        for (k = 0; k < 12 && ok; k = k + 1) begin
            rng = lfsr(rng);
            run_frame(2'h3, rng[15:8], 1'b0, ok);
            acc = acc + ok;
        end
        cmp("refused", 17'h00000, {16'h0000, ok});
        cmp("filled", 17'h00001, {16'h0000, acc >= 8});
        // Clock enable low must keep the front word despite ready
        ce_r <= 1'b0;
        rdy_mode <= 2'h1;
        repeat (20) @(posedge mclk);
        cmp("frozen", {8'h00, 1'b1, expq[0]},
            {8'h00, result_valid, result_data});
        ce_r <= 1'b1;
        drain;
        $display("test fill and drain done");
        results;
    end
endmodule
